// File: include/pwm_timer_regs_pkg.sv
// Register map, field layout and carrier types for the PWM compare block
package pwm_timer_regs_pkg;

    // Bus geometry
    localparam int unsigned PADDR_W     = 18;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned UNITS       = 2;
    localparam int unsigned SLOTS       = 8;
    localparam int unsigned CMP_REGS    = 4;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_T0_CMP0 = 16'hff84;
    localparam logic [15:0] IDX_T0_CMP1 = 16'hff86;
    localparam logic [15:0] IDX_T0_CMP2 = 16'hff8a;
    localparam logic [15:0] IDX_T0_CMP3 = 16'hff90;
    localparam logic [15:0] IDX_T1_CMP0 = 16'hff9c;
    localparam logic [15:0] IDX_T1_CMP1 = 16'hffb0;
    localparam logic [15:0] IDX_T1_CMP2 = 16'hffb2;
    localparam logic [15:0] IDX_T1_CMP3 = 16'hffb4;
    localparam logic [15:0] IDX_T0_DUAL = 16'hffa0;
    localparam logic [15:0] IDX_T1_DUAL = 16'hffa2;
    localparam logic [15:0] IDX_T0_CTL  = 16'hffc0;
    localparam logic [15:0] IDX_T1_CTL  = 16'hffc2;
    localparam logic [15:0] IDX_T0_IOC  = 16'hffc4;
    localparam logic [15:0] IDX_T1_IOC  = 16'hffc6;
    localparam logic [15:0] IDX_T0_CNT  = 16'hffc8;
    localparam logic [15:0] IDX_T1_CNT  = 16'hffca;

    // Slot numbers inside one unit
    localparam logic [2:0] SLOT_DUAL    = 3'h4;
    localparam logic [2:0] SLOT_CTL     = 3'h5;
    localparam logic [2:0] SLOT_IOC     = 3'h6;
    localparam logic [2:0] SLOT_CNT     = 3'h7;

    // Index table, [unit][slot]
    localparam logic [15:0] IDX_TABLE [UNITS][SLOTS] = '{
        '{IDX_T0_CMP0, IDX_T0_CMP1, IDX_T0_CMP2, IDX_T0_CMP3,
          IDX_T0_DUAL, IDX_T0_CTL, IDX_T0_IOC, IDX_T0_CNT},
        '{IDX_T1_CMP0, IDX_T1_CMP1, IDX_T1_CMP2, IDX_T1_CMP3,
          IDX_T1_DUAL, IDX_T1_CTL, IDX_T1_IOC, IDX_T1_CNT}};

    // Control register fields
    localparam int unsigned CTL_RUN_BIT     = 0;
    localparam int unsigned CTL_PERIOD_BIT  = 1;
    localparam int unsigned CTL_CAPTURE_BIT = 2;
    localparam int unsigned CTL_ILOCK2_BIT  = 3;
    localparam int unsigned CTL_LDSEL_LO    = 4;
    localparam int unsigned CTL_LDSEL_HI    = 5;

    // Output control fields
    localparam int unsigned IOC_EN_A_BIT    = 0;
    localparam int unsigned IOC_EN_B_BIT    = 1;
    localparam int unsigned IOC_INV_A_BIT   = 2;
    localparam int unsigned IOC_INV_B_BIT   = 3;

    localparam logic [CNT_W-1:0] REG_RESET  = 16'h0000;
    localparam logic [1:0]       FULL_WORD  = 2'b11;

    // Unit control, as software writes it
    typedef struct packed {
        logic [1:0] comparator_load_select;
        logic       interlock_two;
        logic       op_control_two;
        logic       period_select_bit;
        logic       count_run_bit;
    } unit_ctrl_t;

    localparam unit_ctrl_t CTRL_RESET = '0;

    // Output control
    typedef struct packed {
        logic inv_b;
        logic inv_a;
        logic en_b;
        logic en_a;
    } unit_ioc_t;

    localparam unit_ioc_t IOC_RESET = '0;

    // Address decode result
    typedef struct packed {
        logic       hit;
        logic       unit;
        logic [2:0] slot;
    } reg_sel_t;

endpackage : pwm_timer_regs_pkg

// File: src/pwm_timer_compare_capture_regs.sv
// Two PWM timer units with buffered compare and capture registers
`timescale 1ns/10ps

// Behaviour
// - Each unit counts on a 16-bit up-counter, matched and captured.
// - Four compare registers per unit and two output pins per unit.
// - Unit one has compare registers 0,1,2,3 and one output control.
// - Dual-role register is 16 bits, capture or compare.
// - A control bit selects capture or compare mode for dual-role register.
// - Compare and dual-role registers take whole 16-bit words only.
// - Reset clears every compare and dual-role register to zero.
// - Dual-role writes while running in compare mode wait in a buffer until reload.
// - Compare writes while running wait in a buffer until reload.
// - Period select 0: reload when counter equals compare register one.
// - Period select 1: reload when counter equals compare register three.
// - Interlock mode two: dual-role buffer loads on selected comparator event.
// - Interlock mode two: compare buffers load on selected comparator event.
// - Rewriting an unchanged value is a normal buffered write.
// - Capture mode copies counter into dual-role register on trigger.
// - Capture trigger is a comparator output edge or external irq zero.
// - Run bit 0 stops counter at zero; 1 enables counting.
module pwm_timer_compare_capture_regs
    import pwm_timer_regs_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [DATA_W-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [2:0]         comparator_out,
    input  wire logic               external_irq_zero,
    output logic                    unit0_output_a,
    output logic                    unit0_output_b,
    output logic                    unit1_output_a,
    output logic                    unit1_output_b,
    output logic      [UNITS-1:0]   adc_trigger
);

    // Slots 0..3 compare registers, slot 4 the dual-role register
    localparam int unsigned BUF_N = CMP_REGS + 1;

    logic [CNT_W-1:0]  cnt_q     [UNITS];
    logic [CNT_W-1:0]  act_q     [UNITS][BUF_N];
    logic [CNT_W-1:0]  buf_q     [UNITS][BUF_N];
    logic [BUF_N-1:0]  pend_q    [UNITS];
    unit_ctrl_t        ctrl_q    [UNITS];
    unit_ioc_t         ioc_q     [UNITS];
    logic [1:0]        out_q     [UNITS];
    logic [UNITS-1:0]  adc_q;
    logic [3:0]        src_q;
    logic [3:0]        src_rise;
    logic [DATA_W-1:0] prdata_q;
    logic              pslverr_q;
    logic [DATA_W-1:0] rdata_d;
    logic              err_d;
    reg_sel_t          sel;
    logic              wr_en;

    // Map a word index onto unit and slot
    function automatic reg_sel_t decode(input logic [PADDR_W-1:0] addr);
        reg_sel_t r;
        r = '0;
        for (int u = 0; u < UNITS; u++)
        begin
            for (int s = 0; s < SLOTS; s++)
            begin
                if (addr[1:0] == 2'b00 &&
                    addr[PADDR_W-1:2] == IDX_TABLE[u][s])
                begin
                    r.hit  = 1'b1;
                    r.unit = u[0];
                    r.slot = s[2:0];
                end
            end
        end
        return r;
    endfunction : decode

    assign sel = decode(paddr);

    // Read data and error picked during setup, shown in access
    always_comb
    begin
        rdata_d = '0;
        err_d   = !sel.hit;
        if (sel.hit)
        begin
            if (sel.slot < SLOT_CTL)
            begin
                rdata_d[CNT_W-1:0] = act_q[sel.unit][sel.slot];
                // Byte writes refused on value registers
                err_d = pwrite && (pstrb[1:0] != FULL_WORD);
            end
            else if (sel.slot == SLOT_CTL)
            begin
                rdata_d[$bits(unit_ctrl_t)-1:0] = ctrl_q[sel.unit];
            end
            else if (sel.slot == SLOT_IOC)
            begin
                rdata_d[$bits(unit_ioc_t)-1:0] = ioc_q[sel.unit];
            end
            else
            begin
                rdata_d[CNT_W-1:0] = cnt_q[sel.unit];
                err_d = pwrite; // Counter is read only
            end
        end
    end

    // Registered answer; zero wait states so pready stays high
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_q  <= pwrite ? '0 : rdata_d;
            pslverr_q <= err_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign pready  = 1'b1;

    // Write commits only at the completing access edge
    assign wr_en = psel && penable && pwrite && sel.hit && !pslverr_q;

    // Event sources: comparators 0..2 and external irq zero
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_q <= '0;
        end
        else
        begin
            src_q <= {external_irq_zero, comparator_out};
        end
    end

    // Rising edge counts as a detected event
    assign src_rise = {external_irq_zero, comparator_out} & ~src_q;

    // Adc trigger pulses come from flip-flops
    assign adc_trigger    = adc_q;
    assign unit0_output_a = out_q[0][0];
    assign unit0_output_b = out_q[0][1];
    assign unit1_output_a = out_q[1][0];
    assign unit1_output_b = out_q[1][1];

    genvar g;
    genvar k;
    generate
        for (g = 0; g < UNITS; g++)
        begin : g_unit
            logic             run;
            logic             capture_mode;
            logic             period_match;
            logic             load_evt;
            logic             reload;
            logic             unit_wr;
            logic [CNT_W-1:0] period_val;

            assign run          = ctrl_q[g].count_run_bit;
            assign capture_mode = ctrl_q[g].op_control_two;
            // Period end is compare register three or one
            assign period_val   = ctrl_q[g].period_select_bit ?
                                  act_q[g][3] : act_q[g][1];
            assign period_match = run && (cnt_q[g] == period_val);
            assign load_evt     =
                src_rise[ctrl_q[g].comparator_load_select];
            // One strobe reloads every buffer of the unit
            assign reload = run && (ctrl_q[g].interlock_two ?
                            load_evt : period_match);
            assign unit_wr = wr_en && (sel.unit == g[0]);

            // Counter clears on period match, holds zero when stopped
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cnt_q[g] <= REG_RESET;
                end
                else if (!run)
                begin
                    cnt_q[g] <= REG_RESET;
                end
                else if (period_match)
                begin
                    cnt_q[g] <= REG_RESET;
                end
                else
                begin
                    cnt_q[g] <= cnt_q[g] + 16'h0001;
                end
            end

            // Control and output control registers
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    ctrl_q[g] <= CTRL_RESET;
                    ioc_q[g]  <= IOC_RESET;
                end
                else if (unit_wr && sel.slot == SLOT_CTL)
                begin
                    ctrl_q[g] <= pwdata[$bits(unit_ctrl_t)-1:0];
                end
                else if (unit_wr && sel.slot == SLOT_IOC)
                begin
                    ioc_q[g] <= pwdata[$bits(unit_ioc_t)-1:0];
                end
            end

            for (k = 0; k < BUF_N; k++)
            begin : g_reg
                logic slot_wr;
                logic is_dual;

                assign slot_wr = unit_wr && (sel.slot == 3'(k));
                assign is_dual = (k == BUF_N - 1);

                // Buffer catches every running write except capture-mode dual-role, same value too
                always_ff @(posedge core_clk or negedge arst_n)
                begin
                    if (!arst_n)
                    begin
                        buf_q[g][k]  <= REG_RESET;
                        pend_q[g][k] <= 1'b0;
                    end
                    else if (slot_wr && run &&
                             !(is_dual && capture_mode))
                    begin
                        buf_q[g][k]  <= pwdata[CNT_W-1:0];
                        pend_q[g][k] <= 1'b1;
                    end
                    else if (reload || !run)
                    begin
                        pend_q[g][k] <= 1'b0;
                    end
                end

                // Active value: direct when stopped or capture-mode dual-role, else at reload
                always_ff @(posedge core_clk or negedge arst_n)
                begin
                    if (!arst_n)
                    begin
                        act_q[g][k] <= REG_RESET;
                    end
                    else if (is_dual && capture_mode &&
                             run && load_evt)
                    begin
                        act_q[g][k] <= cnt_q[g];
                    end
                    else if (slot_wr &&
                             (!run || (is_dual && capture_mode)))
                    begin
                        act_q[g][k] <= pwdata[CNT_W-1:0];
                    end
                    else if (reload && pend_q[g][k])
                    begin
                        act_q[g][k] <= buf_q[g][k];
                    end
                end
            end

            // Two outputs per unit, enabled and optionally inverted
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    out_q[g] <= 2'b00;
                end
                else
                begin
                    out_q[g][0] <= ioc_q[g].en_a &&
                        ((run && cnt_q[g] < act_q[g][0]) ^
                         ioc_q[g].inv_a);
                    out_q[g][1] <= ioc_q[g].en_b &&
                        ((run && cnt_q[g] < act_q[g][2]) ^
                         ioc_q[g].inv_b);
                end
            end

            // Adc start pulse on dual-role match in compare mode
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    adc_q[g] <= 1'b0;
                end
                else
                begin
                    adc_q[g] <= run && !capture_mode &&
                                (cnt_q[g] == act_q[g][BUF_N-1]);
                end
            end
        end
    endgenerate

endmodule : pwm_timer_compare_capture_regs

// File: test/pwm_regs_asserts.sv
// Port-level checks for the PWM compare block
`timescale 1ns/10ps
module pwm_regs_asserts
    import pwm_timer_regs_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               arst_n,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [3:0]         pstrb,
    input wire logic [DATA_W-1:0]  prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [UNITS-1:0]   adc_trigger,
    input wire logic               unit0_output_a,
    input wire logic               unit1_output_a
);
    logic [15:0] idx;
    logic        acc;
    logic        hit;
    logic        vhit;

    // Decode against the index table; slots below 5 hold values
    assign idx = paddr[17:2];
    assign acc = psel && penable;
    always_comb
    begin
        hit  = 1'b0;
        vhit = 1'b0;
        for (int u = 0; u < UNITS; u++)
            for (int s = 0; s < SLOTS; s++)
                if (idx == IDX_TABLE[u][s])
                begin
                    hit  = 1'b1;
                    vhit = vhit || (s < 5);
                end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Zero wait states and clean read data
    ready_high_a: assert property (pready)
        else $error("pready low");
    upper_zero_a: assert property (
        acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    err_read_a: assert property (
        acc && !pwrite && pslverr |-> prdata == '0)
        else $error("refused read not zero");
    // Refusals must flag an error
    misalign_err_a: assert property (
        acc && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access accepted");
    unmapped_err_a: assert property (acc && !hit |-> pslverr)
        else $error("unmapped access accepted");
    strobe_err_a: assert property (
        acc && pwrite && vhit && pstrb[1:0] != FULL_WORD |-> pslverr)
        else $error("partial write accepted");
    cnt_ro_a: assert property (
        acc && pwrite && (idx == IDX_T0_CNT || idx == IDX_T1_CNT)
        |-> pslverr)
        else $error("counter write accepted");
    word_ok_a: assert property (
        acc && pwrite && vhit && paddr[1:0] == 2'b00 &&
        pstrb[1:0] == FULL_WORD |-> !pslverr)
        else $error("full word write refused");
    // ADC triggers and both A outputs quiet on the first edge after reset
    reset_quiet_a: assert property (
        !$past(arst_n) |->
        {adc_trigger, unit0_output_a, unit1_output_a} == '0)
        else $error("outputs active after reset");
endmodule : pwm_regs_asserts

bind pwm_timer_compare_capture_regs pwm_regs_asserts chk (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_trigger(adc_trigger),
    .unit0_output_a(unit0_output_a), .unit1_output_a(unit1_output_a));

// File: test/tb.sv
// Self-checking bench for the PWM compare and capture registers
`timescale 1ns/10ps
module tb
    import pwm_timer_regs_pkg::*;
;
    logic               core_clk = 1'b0;
    logic               arst_n   = 1'b0;
    logic               psel     = 1'b0;
    logic               penable  = 1'b0;
    logic               pwrite   = 1'b0;
    logic [PADDR_W-1:0] paddr    = '0;
    logic [DATA_W-1:0]  pwdata   = '0;
    logic [3:0]         pstrb    = '0;
    logic [3:0]         ev       = '0;
    logic [DATA_W-1:0]  prdata;
    logic               pready;
    logic               pslverr;
    logic [3:0]         outs;
    logic [UNITS-1:0]   adc_trigger;
    int                 err_total = 0;
    int                 checks    = 0;

    pwm_timer_compare_capture_regs dut (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_out(ev[2:0]),
        .external_irq_zero(ev[3]), .unit0_output_a(outs[0]),
        .unit0_output_b(outs[1]), .unit1_output_a(outs[2]),
        .unit1_output_b(outs[3]), .adc_trigger(adc_trigger));

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    task automatic complete_run;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, request held until pready is sampled high
    task automatic bus(input logic w, input logic [17:0] a,
                       input logic [15:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic e);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] i, input logic [15:0] v);
        logic [31:0] rd;
        logic        e;
        bus(1'b1, {i, 2'b00}, v, 4'hf, rd, e);
        check(32'(e), 32'h0000_0000);
    endtask : wr

    task automatic rdc(input logic [15:0] i, input logic [15:0] v);
        logic [31:0] rd;
        logic        e;
        bus(1'b0, {i, 2'b00}, 16'h0000, 4'h0, rd, e);
        check(rd, {16'h0000, v});
    endtask : rdc

    task automatic refused(input logic w, input logic [17:0] a,
                           input logic [3:0] s);
        logic [31:0] rd;
        logic        e;
        bus(w, a, 16'h5555, s, rd, e);
        check(32'(e), 32'h0000_0001);
    endtask : refused

    // Event inputs high for three cycles, then low for three
    task automatic pulse(input logic [3:0] v);
        @(posedge core_clk);
        ev <= v;
        repeat (3) @(posedge core_clk);
        ev <= 4'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic t_stopped;
        for (int u = 0; u < UNITS; u++)
            for (int s = 0; s < 5; s++)
                rdc(IDX_TABLE[u][s], REG_RESET);
        for (int u = 0; u < UNITS; u++)
            for (int s = 0; s < 5; s++)
            begin
                wr(IDX_TABLE[u][s], 16'(16'h1000 * (u + 1) + s));
                rdc(IDX_TABLE[u][s], 16'(16'h1000 * (u + 1) + s));
            end
    endtask : t_stopped

    task automatic t_refuse;
        refused(1'b1, {IDX_T0_CMP0, 2'b00}, 4'b0001);
        rdc(IDX_T0_CMP0, 16'h1000);
        refused(1'b0, {16'hff00, 2'b00}, 4'h0);
        refused(1'b1, {IDX_T0_CNT, 2'b00}, 4'hf);
        refused(1'b0, {IDX_T0_CMP1, 2'b10}, 4'h0);
    endtask : t_refuse

    // Period match on register one or three, chosen by ps
    task automatic t_reload(input logic ps);
        int n;
        wr(IDX_T0_CMP0, 16'h0200);
        wr(IDX_T0_CMP1, ps ? 16'hffff : 16'h0014);
        wr(IDX_T0_CMP3, ps ? 16'h0014 : 16'hffff);
        wr(IDX_T0_DUAL, 16'h0005);
        wr(IDX_T0_IOC, 16'h000b);
        wr(IDX_T0_CTL, {14'h0000, ps, 1'b1});
        wr(IDX_T0_CMP0, 16'h0111);
        wr(IDX_T0_CMP2, 16'h0022);
        rdc(IDX_T0_CMP0, 16'h0200);
        // Period of 21 cycles: two dual-role matches fall in this window
        n = 0;
        repeat (48)
        begin
            @(negedge core_clk);
            n += int'(adc_trigger[0]);
        end
        check(32'(n), 32'h0000_0002);
        rdc(IDX_T0_CMP0, 16'h0111);
        rdc(IDX_T0_CMP2, 16'h0022);
        check(32'(outs[0]), 32'h0000_0001);
        check(32'(outs[1]), 32'h0000_0000);
        // Refresh of the active value must replace a pending one
        wr(IDX_T0_CMP0, 16'h0222);
        wr(IDX_T0_CMP0, 16'h0111);
        repeat (24) @(posedge core_clk);
        rdc(IDX_T0_CMP0, 16'h0111);
        wr(IDX_T0_CTL, 16'h0000);
        repeat (3) @(posedge core_clk);
        check(32'(outs[0]), 32'h0000_0000);
        check(32'(outs[1]), 32'h0000_0001);
    endtask : t_reload

    // Interlock two, load on comparator one only
    task automatic t_ilock;
        wr(IDX_T0_CMP1, 16'hffff);
        wr(IDX_T0_CMP3, 16'hffff);
        wr(IDX_T0_CMP2, 16'h0005);
        wr(IDX_T0_DUAL, 16'h0007);
        wr(IDX_T0_CTL, 16'h0019);
        wr(IDX_T0_CMP2, 16'h0033);
        wr(IDX_T0_DUAL, 16'h0044);
        pulse(4'b0001);
        rdc(IDX_T0_CMP2, 16'h0005);
        pulse(4'b0010);
        rdc(IDX_T0_CMP2, 16'h0033);
        rdc(IDX_T0_DUAL, 16'h0044);
        wr(IDX_T0_CTL, 16'h0000);
    endtask : t_ilock

    // Capture on the external input; reads kept well apart
    task automatic t_capture;
        logic [31:0] c1;
        logic [31:0] c2;
        logic        e;
        wr(IDX_T1_IOC, 16'h0001);
        wr(IDX_T1_CTL, 16'h0035);
        pulse(4'b1000);
        bus(1'b0, {IDX_T1_DUAL, 2'b00}, 16'h0000, 4'h0, c1, e);
        pulse(4'b1000);
        bus(1'b0, {IDX_T1_DUAL, 2'b00}, 16'h0000, 4'h0, c2, e);
        check(c2 - c1, 32'h0000_000a);
        check(32'(c1 < 32'h0000_0100), 32'h0000_0001);
        check(32'(outs[3:2]), 32'h0000_0001);
        wr(IDX_T1_CTL, 16'h0000);
    endtask : t_capture

    // Main sequence after a five-cycle reset
    initial
    begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_stopped;
        t_refuse;
        t_reload(1'b0);
        t_reload(1'b1);
        t_ilock;
        t_capture;
        complete_run;
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        complete_run;
    end
endmodule : tb
